// >>> src/loop_ctrl_pkg.sv
package loop_ctrl_pkg;

  // Word addresses of the memory-mapped loop registers (16-bit data words)
  localparam logic [15:0] ADDR_OUTER_START_HI = 16'h003C;
  localparam logic [15:0] ADDR_OUTER_START_LO = 16'h003D;
  localparam logic [15:0] ADDR_OUTER_END_HI   = 16'h0040;
  localparam logic [15:0] ADDR_OUTER_END_LO   = 16'h0041;
  localparam logic [15:0] ADDR_INNER_START_HI = 16'h0042;
  localparam logic [15:0] ADDR_INNER_START_LO = 16'h0043;
  localparam logic [15:0] ADDR_INNER_END_HI   = 16'h0044;
  localparam logic [15:0] ADDR_INNER_END_LO   = 16'h0045;
  localparam logic [15:0] ADDR_OUTER_COUNT    = 16'h001A;
  localparam logic [15:0] ADDR_INNER_COUNT    = 16'h001B;
  localparam logic [15:0] ADDR_INNER_SHADOW   = 16'h001C;
  // Status register one, full and protected aliases
  localparam logic [15:0] ADDR_ST1_FULL       = 16'h0047;
  localparam logic [15:0] ADDR_ST1_PROT       = 16'h0007;

  // Field positions inside status register one
  localparam int unsigned LOOP_ACTIVE_POS = 15;
  localparam int unsigned COMPAT_POS      = 5;

  // Mask of status register one bits that protected-alias writes cannot change
  localparam logic [15:0] ST1_PROT_MASK = 16'h0420;
  // Reset value of status register one
  localparam logic [15:0] ST1_RESET     = 16'h2920;

  // High address word carries only bits 23..16 in its low byte
  localparam int unsigned ADDR_HI_BITS = 8;

  // Register bus request from the CPU data path
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Program-flow events from the decoder and sequencer
  typedef struct packed {
    logic        repeat_decode;
    logic        end_reached;
    logic        call_or_int;
    logic [23:0] fetch_addr;
  } flow_evt_t;

  // Which level is in service
  typedef enum logic [1:0] {
    LVL_IDLE,
    LVL_OUTER,
    LVL_INNER
  } level_t;

endpackage

// >>> src/block_repeat_loop_control.sv
`timescale 1ns/1ps
// How it works
// - native mode: active outer means inner registers
// - record active loops on call or interrupt
// - compat mode uses only outer registers
// - compat repeat instruction sets loop-active flag
// - flag clears when loop ends, outer count zero
// - software clearing flag stops compat loop
// - repeat counters are 16 bits wide
// - start addresses are 24 bits wide
// - end addresses are 24 bits wide
// - inner count load also loads shadow
// - inner loop start reloads count from shadow
// - 24-bit addresses split high byte, low word
// - protected alias keeps newer bits unchanged
module block_repeat_loop_control #(
  parameter int unsigned CNT_W  = 16,
  parameter int unsigned ADDR_W = 24
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  input  wire loop_ctrl_pkg::reg_req_t req_i,
  input  wire loop_ctrl_pkg::flow_evt_t evt_i,
  input  wire logic [ADDR_W-1:0]       rpt_start_i,
  input  wire logic [ADDR_W-1:0]       rpt_end_i,
  input  wire logic [CNT_W-1:0]        rpt_count_i,
  output logic [15:0]                  rdata_o,
  output logic                         redirect_o,
  output logic [ADDR_W-1:0]            redirect_addr_o,
  output logic                         loop_active_flag_o,
  output logic                         legacy_compat_mode_bit_o,
  output logic [1:0]                   control_flow_context_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [CNT_W-1:0]  outer_cnt_q;     // Extra passes of outer block
  logic [CNT_W-1:0]  inner_cnt_q;     // Extra passes of inner block
  logic [CNT_W-1:0]  shadow_q;        // Inner count save copy
  logic [ADDR_W-1:0] outer_start_q;   // First instruction, outer
  logic [ADDR_W-1:0] outer_end_q;     // Last instruction, outer
  logic [ADDR_W-1:0] inner_start_q;   // First instruction, inner
  logic [ADDR_W-1:0] inner_end_q;     // Last instruction, inner
  logic [15:0]       st1_q;           // Status register one
  logic              outer_run_q;     // Outer loop running
  logic              inner_run_q;     // Inner loop running
  loop_ctrl_pkg::level_t level_q;     // Level currently sequenced

  logic compat;
  logic use_inner;
  logic outer_end_hit;
  logic inner_end_hit;
  logic wr_st1_full;
  logic wr_st1_prot;
  logic flag_clr_sw;

  assign compat = st1_q[loop_ctrl_pkg::COMPAT_POS];
  // Inner level only in native mode and only behind a running outer loop
  assign use_inner = !compat && outer_run_q;
  // Inner end wins if both end addresses coincide on the same fetch
  assign inner_end_hit = inner_run_q && evt_i.end_reached && (evt_i.fetch_addr == inner_end_q);
  assign outer_end_hit = outer_run_q && !inner_end_hit && evt_i.end_reached
                         && (evt_i.fetch_addr == outer_end_q);
  assign wr_st1_full = req_i.wr && (req_i.addr == loop_ctrl_pkg::ADDR_ST1_FULL);
  assign wr_st1_prot = req_i.wr && (req_i.addr == loop_ctrl_pkg::ADDR_ST1_PROT);
  assign flag_clr_sw = (wr_st1_full || wr_st1_prot)
                       && !req_i.wdata[loop_ctrl_pkg::LOOP_ACTIVE_POS];

  ////////////////////////////////////////////////////////////////////////////
  // Status register one: alias writes and hardware loop flag
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st1_q <= loop_ctrl_pkg::ST1_RESET;
    end
    else
    begin
      // Later assignments below override the bus write bit by bit
      if (wr_st1_full)
      begin
        st1_q <= req_i.wdata;
      end
      else if (wr_st1_prot)
      begin
        // Protected alias leaves the newer-architecture bits alone
        st1_q <= (st1_q & loop_ctrl_pkg::ST1_PROT_MASK)
                 | (req_i.wdata & ~loop_ctrl_pkg::ST1_PROT_MASK);
      end
      // Hardware clears the flag at final outer end
      if (outer_end_hit && outer_cnt_q == '0)
      begin
        st1_q[loop_ctrl_pkg::LOOP_ACTIVE_POS] <= 1'b0;
      end
      // A new outer-level loop start sets the flag; being last, set wins over any clear
      if (evt_i.repeat_decode && !use_inner)
      begin
        st1_q[loop_ctrl_pkg::LOOP_ACTIVE_POS] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop run state and level selection
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      outer_run_q <= 1'b0;
      inner_run_q <= 1'b0;
      level_q     <= loop_ctrl_pkg::LVL_IDLE;
    end
    else if (evt_i.repeat_decode)
    begin
      if (use_inner)
      begin
        inner_run_q <= 1'b1;
        level_q     <= loop_ctrl_pkg::LVL_INNER;
      end
      else
      begin
        outer_run_q <= 1'b1;
        inner_run_q <= 1'b0;
        level_q     <= loop_ctrl_pkg::LVL_OUTER;
      end
    end
    else
    begin
      // Software clearing the flag in compat mode stops the loop
      if (compat && flag_clr_sw && outer_run_q)
      begin
        outer_run_q <= 1'b0;
        level_q     <= loop_ctrl_pkg::LVL_IDLE;
      end
      else if (inner_end_hit && inner_cnt_q == '0)
      begin
        inner_run_q <= 1'b0;
        level_q     <= loop_ctrl_pkg::LVL_OUTER;
      end
      else if (outer_end_hit && outer_cnt_q == '0)
      begin
        outer_run_q <= 1'b0;
        level_q     <= loop_ctrl_pkg::LVL_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters: loads, shadow copy and per-pass decrement
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      outer_cnt_q <= '0;
      inner_cnt_q <= '0;
      shadow_q    <= '0;
    end
    else
    begin
      if (req_i.wr && req_i.addr == loop_ctrl_pkg::ADDR_OUTER_COUNT)
      begin
        outer_cnt_q <= req_i.wdata[CNT_W-1:0];
      end
      else if (outer_end_hit && outer_cnt_q != '0)
      begin
        outer_cnt_q <= outer_cnt_q - 1'b1;
      end
      if (req_i.wr && req_i.addr == loop_ctrl_pkg::ADDR_INNER_COUNT)
      begin
        inner_cnt_q <= req_i.wdata[CNT_W-1:0];
        shadow_q    <= req_i.wdata[CNT_W-1:0];
      end
      else if (req_i.wr && req_i.addr == loop_ctrl_pkg::ADDR_INNER_SHADOW)
      begin
        shadow_q <= req_i.wdata[CNT_W-1:0];
      end
      else if (evt_i.repeat_decode && use_inner)
      begin
        // A start of the inner loop restores its count unless a count or shadow write lands in the same cycle
        inner_cnt_q <= shadow_q;
      end
      else if (inner_end_hit && inner_cnt_q != '0)
      begin
        inner_cnt_q <= inner_cnt_q - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address registers: instruction load or split word writes
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      outer_start_q <= '0;
      outer_end_q   <= '0;
      inner_start_q <= '0;
      inner_end_q   <= '0;
    end
    else if (evt_i.repeat_decode)
    begin
      if (use_inner)
      begin
        inner_start_q <= rpt_start_i;
        inner_end_q   <= rpt_end_i;
      end
      else
      begin
        outer_start_q <= rpt_start_i;
        outer_end_q   <= rpt_end_i;
      end
    end
    else if (req_i.wr)
    begin
      // Upper byte of the high word is ignored
      if (req_i.addr == loop_ctrl_pkg::ADDR_OUTER_START_HI)
      begin
        outer_start_q[23:16] <= req_i.wdata[loop_ctrl_pkg::ADDR_HI_BITS-1:0];
      end
      else if (req_i.addr == loop_ctrl_pkg::ADDR_OUTER_START_LO)
      begin
        outer_start_q[15:0] <= req_i.wdata;
      end
      else if (req_i.addr == loop_ctrl_pkg::ADDR_OUTER_END_HI)
      begin
        outer_end_q[23:16] <= req_i.wdata[loop_ctrl_pkg::ADDR_HI_BITS-1:0];
      end
      else if (req_i.addr == loop_ctrl_pkg::ADDR_OUTER_END_LO)
      begin
        outer_end_q[15:0] <= req_i.wdata;
      end
      else if (req_i.addr == loop_ctrl_pkg::ADDR_INNER_START_HI)
      begin
        inner_start_q[23:16] <= req_i.wdata[loop_ctrl_pkg::ADDR_HI_BITS-1:0];
      end
      else if (req_i.addr == loop_ctrl_pkg::ADDR_INNER_START_LO)
      begin
        inner_start_q[15:0] <= req_i.wdata;
      end
      else if (req_i.addr == loop_ctrl_pkg::ADDR_INNER_END_HI)
      begin
        inner_end_q[23:16] <= req_i.wdata[loop_ctrl_pkg::ADDR_HI_BITS-1:0];
      end
      else if (req_i.addr == loop_ctrl_pkg::ADDR_INNER_END_LO)
      begin
        inner_end_q[15:0] <= req_i.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch redirect toward the sequencer, one cycle after the end fetch
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      redirect_o      <= 1'b0;
      redirect_addr_o <= '0;
    end
    else if (inner_end_hit && inner_cnt_q != '0)
    begin
      redirect_o      <= 1'b1;
      redirect_addr_o <= inner_start_q;
    end
    else if (outer_end_hit && outer_cnt_q != '0)
    begin
      redirect_o      <= 1'b1;
      redirect_addr_o <= outer_start_q;
    end
    else
    begin
      redirect_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active-loop record for calls and interrupts
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      control_flow_context_o <= '0;
    end
    else if (evt_i.call_or_int)
    begin
      // Saved so the subroutine may reuse the outer level
      control_flow_context_o <= {inner_run_q, outer_run_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and mirrored flags
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rdata_o                  <= '0;
      loop_active_flag_o       <= 1'b0;
      legacy_compat_mode_bit_o <= 1'b0;
    end
    else
    begin
      loop_active_flag_o       <= st1_q[loop_ctrl_pkg::LOOP_ACTIVE_POS];
      legacy_compat_mode_bit_o <= compat;
      if (!req_i.rd)
        rdata_o <= rdata_o;
      else if (req_i.addr == loop_ctrl_pkg::ADDR_OUTER_START_HI)
        rdata_o <= {8'h00, outer_start_q[23:16]};
      else if (req_i.addr == loop_ctrl_pkg::ADDR_OUTER_START_LO)
        rdata_o <= outer_start_q[15:0];
      else if (req_i.addr == loop_ctrl_pkg::ADDR_OUTER_END_HI)
        rdata_o <= {8'h00, outer_end_q[23:16]};
      else if (req_i.addr == loop_ctrl_pkg::ADDR_OUTER_END_LO)
        rdata_o <= outer_end_q[15:0];
      else if (req_i.addr == loop_ctrl_pkg::ADDR_INNER_START_HI)
        rdata_o <= {8'h00, inner_start_q[23:16]};
      else if (req_i.addr == loop_ctrl_pkg::ADDR_INNER_START_LO)
        rdata_o <= inner_start_q[15:0];
      else if (req_i.addr == loop_ctrl_pkg::ADDR_INNER_END_HI)
        rdata_o <= {8'h00, inner_end_q[23:16]};
      else if (req_i.addr == loop_ctrl_pkg::ADDR_INNER_END_LO)
        rdata_o <= inner_end_q[15:0];
      else if (req_i.addr == loop_ctrl_pkg::ADDR_OUTER_COUNT)
        rdata_o <= outer_cnt_q;
      else if (req_i.addr == loop_ctrl_pkg::ADDR_INNER_COUNT)
        rdata_o <= inner_cnt_q;
      else if (req_i.addr == loop_ctrl_pkg::ADDR_INNER_SHADOW)
        rdata_o <= shadow_q;
      else if (req_i.addr == loop_ctrl_pkg::ADDR_ST1_FULL)
        rdata_o <= st1_q;
      else if (req_i.addr == loop_ctrl_pkg::ADDR_ST1_PROT)
        rdata_o <= st1_q & ~loop_ctrl_pkg::ST1_PROT_MASK;
      else
        rdata_o <= '0;
    end
  end

endmodule

// >>> dv/block_repeat_loop_control_properties.sv
`timescale 1ns/1ps
// Watches the loop controller from its ports only
module block_repeat_loop_control_chk #(
  parameter int unsigned CNT_W  = 16,
  parameter int unsigned ADDR_W = 24
) (
  input wire logic                     ref_clk_i,
  input wire logic                     rst_i,
  input wire loop_ctrl_pkg::reg_req_t  req_i,
  input wire loop_ctrl_pkg::flow_evt_t evt_i,
  input wire logic [ADDR_W-1:0]        rpt_start_i,
  input wire logic [ADDR_W-1:0]        rpt_end_i,
  input wire logic [CNT_W-1:0]         rpt_count_i,
  input wire logic [15:0]              rdata_o,
  input wire logic                     redirect_o,
  input wire logic [ADDR_W-1:0]        redirect_addr_o,
  input wire logic                     loop_active_flag_o,
  input wire logic                     legacy_compat_mode_bit_o,
  input wire logic [1:0]               control_flow_context_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Protected alias always reads the guarded bits as zero
  property p_prot_read;
    req_i.rd && req_i.addr == loop_ctrl_pkg::ADDR_ST1_PROT
    |=> (rdata_o & loop_ctrl_pkg::ST1_PROT_MASK) == 16'h0000;
  endproperty
  a_prot_read: assert property (p_prot_read)
    else $error("guarded bits visible");
  // Upper byte of a high address word is ignored and reads zero
  property p_hi_byte;
    req_i.rd && req_i.addr inside {16'h003C, 16'h0040, 16'h0042, 16'h0044}
    |=> rdata_o[15:8] == 8'h00;
  endproperty
  a_hi_byte: assert property (p_hi_byte)
    else $error("high byte not zero");
  // A refetch only ever follows a completed instruction
  property p_redirect_cause;
    redirect_o |-> $past(evt_i.end_reached);
  endproperty
  a_redirect_cause: assert property (p_redirect_cause)
    else $error("redirect without end");
  // Legacy repeat raises the flag after register plus mirror
  property p_flag_set;
    evt_i.repeat_decode && legacy_compat_mode_bit_o |=> ##1 loop_active_flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set");
  // Context only moves on a call or interrupt
  property p_ctx_stable;
    !$past(evt_i.call_or_int) |-> $stable(control_flow_context_o);
  endproperty
  a_ctx_stable: assert property (p_ctx_stable)
    else $error("context moved");
  // Legacy mode never starts an inner loop
  property p_no_inner;
    evt_i.call_or_int && legacy_compat_mode_bit_o |=> !control_flow_context_o[1];
  endproperty
  a_no_inner: assert property (p_no_inner)
    else $error("inner level used");
  // Decode guard covers the two-cycle lag of the flag mirror
  property p_stop;
    evt_i.end_reached && legacy_compat_mode_bit_o && !loop_active_flag_o
    && !$past(evt_i.repeat_decode) && !$past(evt_i.repeat_decode, 2) |=> !redirect_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stopped loop refetched");
  // Shadow read right after an inner count write shows the written value
  property p_shadow;
    req_i.rd && req_i.addr == loop_ctrl_pkg::ADDR_INNER_SHADOW && $past(req_i.wr, 2)
    && $past(req_i.addr, 2) == loop_ctrl_pkg::ADDR_INNER_COUNT
    |=> rdata_o == $past(req_i.wdata, 3);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow not loaded");
endmodule

bind block_repeat_loop_control block_repeat_loop_control_chk #(
  .CNT_W(CNT_W), .ADDR_W(ADDR_W)) chk_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i), .evt_i(evt_i),
  .rpt_start_i(rpt_start_i), .rpt_end_i(rpt_end_i), .rpt_count_i(rpt_count_i),
  .rdata_o(rdata_o), .redirect_o(redirect_o), .redirect_addr_o(redirect_addr_o),
  .loop_active_flag_o(loop_active_flag_o),
  .legacy_compat_mode_bit_o(legacy_compat_mode_bit_o),
  .control_flow_context_o(control_flow_context_o));

// >>> dv/flow_model.sv
`timescale 1ns/1ps
// Decoder and sequencer stand-in: one instruction event per step
module flow_model (
  input  wire logic                ref_clk_i,
  output loop_ctrl_pkg::flow_evt_t evt_o,
  output logic [23:0]              start_o,
  output logic [23:0]              end_o
);
  initial
  begin
    evt_o = '0;
    start_o = '0;
    end_o = '0;
  end
  // Counter writes never come from here, so none lands near a loop end
  task automatic step(input logic dec, fin, call, input logic [23:0] a, s, e);
    @(posedge ref_clk_i);
    evt_o <= '{dec, fin, call, a};
    start_o <= s;
    end_o <= e;
    @(posedge ref_clk_i);
    // Released operands must not keep looking valid
    evt_o <= '{1'b0, 1'b0, 1'b0, ~a};
    start_o <= ~s;
    end_o <= ~e;
  endtask
endmodule

// >>> dv/block_repeat_loop_control_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module block_repeat_loop_control_tb;
  logic                     ref_clk_i = 1'b0;
  logic                     rst_i = 1'b1;
  loop_ctrl_pkg::reg_req_t  req = '0;
  loop_ctrl_pkg::flow_evt_t evt;
  logic [23:0]              st;
  logic [23:0]              en;
  logic [15:0]              rdata;
  logic                     redirect;
  logic [23:0]              raddr;
  logic                     flag;
  logic                     compat;
  logic [1:0]               ctx;
  int                       mismatches = 0;
  int                       comparisons = 0;
  logic [15:0]              hi_addr [4] = '{16'h003C, 16'h0040, 16'h0042, 16'h0044};

  always #12.5 ref_clk_i = ~ref_clk_i;

  block_repeat_loop_control block_repeat_loop_control_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .evt_i(evt),
    .rpt_start_i(st), .rpt_end_i(en), .rpt_count_i(16'h0000), .rdata_o(rdata),
    .redirect_o(redirect), .redirect_addr_o(raddr), .loop_active_flag_o(flag),
    .legacy_compat_mode_bit_o(compat), .control_flow_context_o(ctx));
  flow_model flow_model_i (.ref_clk_i(ref_clk_i), .evt_o(evt), .start_o(st), .end_o(en));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge ref_clk_i);
    req.wr <= 1'b0;
  endtask
  // Read data is registered, so it is looked at just after the taking edge
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
    @(posedge ref_clk_i);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk_i);
    req.rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask
  task automatic rpt(input logic [23:0] s, input logic [23:0] e);
    flow_model_i.step(1'b1, 1'b0, 1'b0, 24'h00_0000, s, e);
  endtask
  task automatic fin(input logic [23:0] a, input logic r, input logic [23:0] ra);
    flow_model_i.step(1'b0, 1'b1, 1'b0, a, 24'h00_0000, 24'h00_0000);
    #1;
    `CHK("redirect", r, redirect)
    if (r)
      `CHK("target", ra, raddr)
  endtask
  task automatic call_evt;
    flow_model_i.step(1'b0, 1'b0, 1'b1, 24'h00_0000, 24'h00_0000, 24'h00_0000);
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    final_report();
  end

  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    tick(2);
    `CHK("compat", 1'b1, compat)
    rd(loop_ctrl_pkg::ADDR_ST1_FULL, loop_ctrl_pkg::ST1_RESET, "status one");
    // Address words, high then low, for all four address registers
    for (int i = 0; i < 4; i++)
    begin
      wr(hi_addr[i], 16'hA5C0 + 16'(i));
      wr(hi_addr[i] + 16'h0001, 16'h5A50 + 16'(i));
      rd(hi_addr[i], 16'h00C0 + 16'(i), "addr hi");
      rd(hi_addr[i] + 16'h0001, 16'h5A50 + 16'(i), "addr lo");
    end
    wr(loop_ctrl_pkg::ADDR_OUTER_COUNT, 16'hFFFF);
    rd(loop_ctrl_pkg::ADDR_OUTER_COUNT, 16'hFFFF, "outer count");
    wr(loop_ctrl_pkg::ADDR_INNER_COUNT, 16'h8001);
    rd(loop_ctrl_pkg::ADDR_INNER_SHADOW, 16'h8001, "shadow");
    rd(16'h0050, 16'h0000, "unmapped");
    wr(loop_ctrl_pkg::ADDR_ST1_PROT, 16'h0000);
    rd(loop_ctrl_pkg::ADDR_ST1_FULL, 16'h0020, "status one");
    wr(loop_ctrl_pkg::ADDR_ST1_PROT, 16'h7FFF);
    rd(loop_ctrl_pkg::ADDR_ST1_PROT, 16'h7BDF, "prot view");
    rd(loop_ctrl_pkg::ADDR_ST1_FULL, 16'h7BFF, "status one");
    wr(loop_ctrl_pkg::ADDR_ST1_FULL, loop_ctrl_pkg::ST1_RESET);
    // Status three lives outside this block; no write here owes it 1100b
    // Legacy loop runs three passes, then stops on a zero count
    wr(loop_ctrl_pkg::ADDR_OUTER_COUNT, 16'h0002);
    rpt(24'h00_0100, 24'h00_0110);
    tick(1);
    `CHK("flag", 1'b1, flag)
    fin(24'h00_0110, 1'b1, 24'h00_0100);
    rd(loop_ctrl_pkg::ADDR_OUTER_COUNT, 16'h0001, "outer count");
    fin(24'h00_0110, 1'b1, 24'h00_0100);
    fin(24'h00_0110, 1'b0, 24'h00_0000);
    tick(1);
    `CHK("flag", 1'b0, flag)
    // A nested legacy repeat takes over the outer registers
    wr(loop_ctrl_pkg::ADDR_OUTER_COUNT, 16'h0001);
    rpt(24'h00_0100, 24'h00_0110);
    rpt(24'h00_0200, 24'h00_0210);
    call_evt();
    `CHK("context", 2'b01, ctx)
    fin(24'h00_0210, 1'b1, 24'h00_0200);
    rd(loop_ctrl_pkg::ADDR_OUTER_START_LO, 16'h0200, "outer start");
    rd(loop_ctrl_pkg::ADDR_INNER_START_LO, 16'h5A52, "inner start");
    fin(24'h00_0210, 1'b0, 24'h00_0000);
    // Software clear of the flag stops a running legacy loop
    wr(loop_ctrl_pkg::ADDR_OUTER_COUNT, 16'h0005);
    rpt(24'h00_0300, 24'h00_0310);
    tick(1);
    wr(loop_ctrl_pkg::ADDR_ST1_FULL, loop_ctrl_pkg::ST1_RESET);
    tick(1);
    fin(24'h00_0310, 1'b0, 24'h00_0000);
    `CHK("flag", 1'b0, flag)
    // Flag and mode cleared in one write, then native nesting
    wr(loop_ctrl_pkg::ADDR_ST1_FULL, 16'h2900);
    tick(2);
    `CHK("compat", 1'b0, compat)
    wr(loop_ctrl_pkg::ADDR_INNER_COUNT, 16'h0003);
    wr(loop_ctrl_pkg::ADDR_OUTER_COUNT, 16'h0001);
    rpt(24'h00_0400, 24'h00_0440);
    rpt(24'h00_0410, 24'h00_0420);
    rd(loop_ctrl_pkg::ADDR_INNER_START_LO, 16'h0410, "inner start");
    rd(loop_ctrl_pkg::ADDR_OUTER_START_LO, 16'h0400, "outer start");
    call_evt();
    `CHK("context", 2'b11, ctx)
    fin(24'h00_0420, 1'b1, 24'h00_0410);
    rd(loop_ctrl_pkg::ADDR_INNER_COUNT, 16'h0002, "inner count");
    rpt(24'h00_0410, 24'h00_0420);
    rd(loop_ctrl_pkg::ADDR_INNER_COUNT, 16'h0003, "inner count");
    rd(loop_ctrl_pkg::ADDR_INNER_SHADOW, 16'h0003, "shadow");
    fin(24'h00_0440, 1'b1, 24'h00_0400);
    // Direct shadow write leaves the live count alone until the next inner start
    wr(loop_ctrl_pkg::ADDR_INNER_SHADOW, 16'h0007);
    rd(loop_ctrl_pkg::ADDR_INNER_SHADOW, 16'h0007, "shadow");
    rd(loop_ctrl_pkg::ADDR_INNER_COUNT, 16'h0003, "inner count");
    rpt(24'h00_0410, 24'h00_0420);
    rd(loop_ctrl_pkg::ADDR_INNER_COUNT, 16'h0007, "inner count");
    // Native outer end on a zero count stops without refetch and drops the flag
    `CHK("flag", 1'b1, flag)
    fin(24'h00_0440, 1'b0, 24'h00_0000);
    tick(1);
    `CHK("flag", 1'b0, flag)
    final_report();
  end
endmodule
